// File: core/pct_pkg.sv
// Constants, types and opcode timing table for the pipelined core sequencer
package pct_pkg;

  // Program counter value taken at reset
  localparam logic [15:0] RESET_PC         = 16'h0000;
  // Longest instruction, in clocks
  localparam logic [3:0]  MAX_CYCLES       = 4'h8;
  // Direct addresses at or above this point select the special space
  localparam logic [7:0]  SPECIAL_BASE     = 8'h80;
  localparam int          IRAM_BYTES       = 256;
  localparam int          SPECIAL_BYTES    = 128;
  // First extended address that is no longer on-chip RAM
  localparam logic [15:0] EXT_ONCHIP_TOP   = 16'h1000;

  // Opcodes that the sequencer treats specially
  localparam logic [7:0] OP_PTR_INC     = 8'hA3;
  localparam logic [7:0] OP_PTR_LOAD    = 8'h90;
  localparam logic [7:0] OP_CODE_PC_RD  = 8'h83;
  localparam logic [7:0] OP_CODE_PTR_RD = 8'h93;
  localparam logic [7:0] OP_PRODUCT     = 8'hA4;
  localparam logic [7:0] OP_DIV         = 8'h84;
  localparam logic [3:0] PRODUCT_CYCLES = 4'h4;
  localparam logic [3:0] DIV_CYCLES     = 4'h8;

  typedef enum logic [1:0] {
    PCT_ST_FETCH = 2'b00,
    PCT_ST_EXEC  = 2'b01,
    PCT_ST_HALT  = 2'b10
  } pct_state_e;

  typedef enum logic [1:0] {
    PCT_XT_NONE    = 2'b00,
    PCT_XT_ONCHIP  = 2'b01,
    PCT_XT_OFFCHIP = 2'b10,
    PCT_XT_FLASH   = 2'b11
  } pct_xtarget_e;

  typedef enum logic {
    PCT_SP_IRAM = 1'b0,
    PCT_SP_SPECIAL = 1'b1
  } pct_space_e;

  // Static timing of one opcode; cycles is the not-taken figure
  typedef struct packed {
    logic [1:0] nbytes;
    logic [3:0] cycles;
    logic       cond;
    logic       jump;
    logic       direct;
  } pct_dec_s;

  // One retired instruction
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [1:0] nbytes;
    logic [3:0] ncycles;
    logic       taken;
    logic       has_direct;
    pct_space_e space;
  } pct_instr_s;

  // One external data move, as retired
  typedef struct packed {
    logic         valid;
    logic         write;
    pct_xtarget_e target;
    logic [15:0]  addr;
  } pct_xmove_s;

  function automatic pct_dec_s pct_mk(input logic [1:0] n,
                                      input logic [3:0] c,
                                      input logic [2:0] f);
    pct_dec_s d;
    d = '{nbytes: n, cycles: c, cond: f[2], jump: f[1], direct: f[0]};
    return d;
  endfunction : pct_mk

  // Bytes and clocks per opcode; f = {cond, jump, direct}
  function automatic pct_dec_s pct_decode(input logic [7:0] op);
    pct_dec_s   d;
    logic [3:0] hi;
    logic [3:0] lo;
    hi = op[7:4];
    lo = op[3:0];
    d  = pct_mk(2'd1, 4'd1, 3'b000);
    if (lo >= 4'h8) begin
      case (hi)
        4'h7:      d = pct_mk(2'd2, 4'd2, 3'b000);
        4'h8, 4'hA: d = pct_mk(2'd2, 4'd2, 3'b001);
        4'hB:      d = pct_mk(2'd3, 4'd3, 3'b100);
        4'hD:      d = pct_mk(2'd2, 4'd2, 3'b100);
        default:   d = pct_mk(2'd1, 4'd1, 3'b000);
      endcase
    end else if (lo >= 4'h6) begin
      case (hi)
        4'h7:      d = pct_mk(2'd2, 4'd2, 3'b000);
        4'h8, 4'hA: d = pct_mk(2'd2, 4'd2, 3'b001);
        4'hB:      d = pct_mk(2'd3, 4'd4, 3'b100);
        default:   d = pct_mk(2'd1, 4'd2, 3'b000);
      endcase
    end else begin
      case (lo)
        4'h5: begin
          case (hi)
            4'h7, 4'h8: d = pct_mk(2'd3, 4'd3, 3'b001);
            4'hB, 4'hD: d = pct_mk(2'd3, 4'd3, 3'b101);
            4'hA:       d = pct_mk(2'd1, 4'd1, 3'b000);
            default:    d = pct_mk(2'd2, 4'd2, 3'b001);
          endcase
        end
        4'h4: begin
          case (hi)
            4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF:
                     d = pct_mk(2'd1, 4'd1, 3'b000);
            4'h8:    d = pct_mk(2'd1, DIV_CYCLES, 3'b000);
            4'hA:    d = pct_mk(2'd1, PRODUCT_CYCLES, 3'b000);
            4'hB:    d = pct_mk(2'd3, 4'd3, 3'b100);
            default: d = pct_mk(2'd2, 4'd2, 3'b000);
          endcase
        end
        4'h1:        d = pct_mk(2'd2, 4'd3, 3'b010);
        4'h0: begin
          case (hi)
            4'h0:             d = pct_mk(2'd1, 4'd1, 3'b000);
            4'h1, 4'h2, 4'h3: d = pct_mk(2'd3, 4'd3, 3'b101);
            4'h4, 4'h5, 4'h6, 4'h7:
                              d = pct_mk(2'd2, 4'd2, 3'b100);
            4'h8:             d = pct_mk(2'd2, 4'd3, 3'b010);
            4'h9:             d = pct_mk(2'd3, 4'd3, 3'b000);
            4'hC, 4'hD:       d = pct_mk(2'd2, 4'd2, 3'b001);
            4'hE, 4'hF:       d = pct_mk(2'd1, 4'd3, 3'b000);
            default:          d = pct_mk(2'd2, 4'd2, 3'b000);
          endcase
        end
        4'h2: begin
          case (hi)
            4'h0, 4'h1:       d = pct_mk(2'd3, 4'd4, 3'b010);
            4'h2, 4'h3:       d = pct_mk(2'd1, 4'd5, 3'b010);
            4'h4, 4'h5, 4'h6: d = pct_mk(2'd2, 4'd2, 3'b001);
            4'hE, 4'hF:       d = pct_mk(2'd1, 4'd3, 3'b000);
            default:          d = pct_mk(2'd2, 4'd2, 3'b000);
          endcase
        end
        default: begin
          case (hi)
            4'h4, 4'h5, 4'h6: d = pct_mk(2'd3, 4'd3, 3'b001);
            4'h7:             d = pct_mk(2'd1, 4'd3, 3'b010);
            4'h8, 4'h9, 4'hE, 4'hF:
                              d = pct_mk(2'd1, 4'd3, 3'b000);
            default:          d = pct_mk(2'd1, 4'd1, 3'b000);
          endcase
        end
      endcase
    end
    return d;
  endfunction : pct_decode

endpackage : pct_pkg

// File: core/pct_core.sv
// Fetch and timing sequencer of the pipelined 8-bit core, with debug control
`timescale 1ns/1ps

module pct_core (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic [7:0]         code_data_i,
  input  wire logic [7:0]         acc_i,
  input  wire logic [7:0]         ri_addr_i,
  input  wire logic               branch_taken_i,
  input  wire logic [15:0]        branch_target_i,
  input  wire logic               flash_wr_en_i,
  input  wire logic               dbg_halt_i,
  input  wire logic               dbg_run_i,
  input  wire logic               dbg_step_i,
  input  wire logic               dbg_bkpt_en_i,
  input  wire logic [15:0]        dbg_bkpt_addr_i,
  input  wire logic               dbg_watch_en_i,
  input  wire logic [7:0]         dbg_watch_addr_i,
  output logic [15:0]             code_addr_o,
  output pct_pkg::pct_instr_s     instr_o,
  output logic                    instr_done_o,
  output logic [15:0]             data_pointer_reg_o,
  output pct_pkg::pct_xmove_s     xmove_o,
  output logic                    dbg_halted_o,
  output logic [15:0]             dbg_pc_o
);

  pct_pkg::pct_state_e state;
  pct_pkg::pct_state_e next_state;
  pct_pkg::pct_dec_s   dec;
  pct_pkg::pct_dec_s   cur_dec;
  logic [3:0]          cnt;
  logic [3:0]          cyc;
  logic [7:0]          opcode;
  logic [7:0]          op1;
  logic [7:0]          op2;
  logic [7:0]          cur_op;
  logic [7:0]          cur_op1;
  logic [7:0]          cur_op2;
  logic                taken;
  logic                step_once;
  logic                step_hold;
  logic                watch_pend;
  logic                bkpt_hit;
  logic                halt_now;
  logic                issue;
  logic                exec;
  logic                base_last;
  logic                last;
  logic                fetch_byte;
  logic                code_rd;
  logic                ext_move;
  logic [15:0]         code_rd_addr;
  logic [15:0]         xaddr;
  logic [15:0]         next_pc;
  logic [15:0]         next_fetch;

  // Cycle bookkeeping; decode straight from the bus on the opcode clock
  always_comb begin
    cur_dec    = (state == pct_pkg::PCT_ST_FETCH) ?
                 pct_pkg::pct_decode(code_data_i) : dec;
    cur_op     = (state == pct_pkg::PCT_ST_FETCH) ? code_data_i : opcode;
    cyc        = (state == pct_pkg::PCT_ST_FETCH) ? 4'h0 : cnt;
    cur_op1    = (cyc == 4'h1) ? code_data_i : op1;
    cur_op2    = (cyc == 4'h2) ? code_data_i : op2;
    bkpt_hit   = dbg_bkpt_en_i && (dbg_pc_o == dbg_bkpt_addr_i);
    halt_now   = (state == pct_pkg::PCT_ST_FETCH) && !step_once &&
                 (dbg_halt_i || bkpt_hit || watch_pend ||
                  step_hold);
    issue      = (state == pct_pkg::PCT_ST_FETCH) && !halt_now;
    exec       = issue || (state == pct_pkg::PCT_ST_EXEC);
    base_last  = exec && !taken &&
                 (cyc == cur_dec.cycles - 4'h1);
    // Taken branch buys exactly one extra clock
    last       = exec && (taken ||
                 (base_last && !(cur_dec.cond && branch_taken_i)));
    fetch_byte = exec && (cyc < {2'b00, cur_dec.nbytes});
    code_rd    = (cur_op == pct_pkg::OP_CODE_PC_RD) ||
                 (cur_op == pct_pkg::OP_CODE_PTR_RD);
    ext_move   = (cur_op[7:5] == 3'b111) && (cur_op[3:2] == 2'b00) &&
                 (cur_op[1:0] != 2'b01);
  end

  // Next fetch address; code byte reads borrow one fetch slot
  always_comb begin
    code_rd_addr = {8'h00, acc_i} +
                ((cur_op == pct_pkg::OP_CODE_PTR_RD) ? data_pointer_reg_o : dbg_pc_o);
    if (last && (cur_dec.jump || taken)) begin
      next_pc = branch_target_i;
    end else if (fetch_byte) begin
      next_pc = dbg_pc_o + 16'h0001;
    end else begin
      next_pc = dbg_pc_o;
    end
    if (exec && code_rd && (cyc == 4'h1)) begin
      next_fetch = code_rd_addr;
    end else begin
      next_fetch = next_pc;
    end
    xaddr = (cur_op[3:0] == 4'h0) ? data_pointer_reg_o : {8'h00, ri_addr_i};
  end

  // Sequencer; halts only on instruction boundaries
  always_comb begin
    case (state)
      pct_pkg::PCT_ST_FETCH: begin
        if (halt_now) begin
          next_state = pct_pkg::PCT_ST_HALT;
        end else if (last) begin
          next_state = pct_pkg::PCT_ST_FETCH;
        end else begin
          next_state = pct_pkg::PCT_ST_EXEC;
        end
      end
      pct_pkg::PCT_ST_EXEC: begin
        next_state = last ? pct_pkg::PCT_ST_FETCH : pct_pkg::PCT_ST_EXEC;
      end
      pct_pkg::PCT_ST_HALT: begin
        if (dbg_step_i || (dbg_run_i && !dbg_halt_i)) begin
          next_state = pct_pkg::PCT_ST_FETCH;
        end else begin
          next_state = pct_pkg::PCT_ST_HALT;
        end
      end
      default: next_state = pct_pkg::PCT_ST_FETCH;
    endcase
  end

  // State, counters and flush at reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state        <= pct_pkg::PCT_ST_FETCH;
      cnt          <= 4'h0;
      taken        <= 1'b0;
      dbg_halted_o <= 1'b0;
    end else begin
      state        <= next_state;
      dbg_halted_o <= (next_state == pct_pkg::PCT_ST_HALT);
      cnt          <= issue ? 4'h1 : cnt + 4'h1;
      if (last) begin
        taken <= 1'b0;
      end else if (base_last && cur_dec.cond && branch_taken_i) begin
        taken <= 1'b1;
      end
    end
  end

  // Program counter and fetch address
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dbg_pc_o    <= pct_pkg::RESET_PC;
      code_addr_o <= pct_pkg::RESET_PC;
    end else begin
      dbg_pc_o    <= next_pc;
      code_addr_o <= next_fetch;
    end
  end

  // Opcode and operand capture, cleared at each issue
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opcode <= 8'h00;
      dec    <= '0;
      op1    <= 8'h00;
      op2    <= 8'h00;
    end else if (issue) begin
      opcode <= code_data_i;
      dec    <= cur_dec;
      op1    <= 8'h00;
      op2    <= 8'h00;
    end else if (exec) begin
      if (fetch_byte && (cyc == 4'h1)) begin
        op1 <= code_data_i;
      end
      if (cyc == 4'h2 && (fetch_byte || code_rd)) begin
        op2 <= code_data_i;
      end
    end
  end

  // Data pointer; single-clock increment keeps the full 16-bit carry
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_pointer_reg_o <= 16'h0000;
    end else if (issue && (code_data_i == pct_pkg::OP_PTR_INC)) begin
      data_pointer_reg_o <= data_pointer_reg_o + 16'h0001;
    end else if (last && (cur_op == pct_pkg::OP_PTR_LOAD)) begin
      data_pointer_reg_o <= {cur_op1, cur_op2};
    end
  end

  // Debug one-shot and watchpoint; a hit beats the clear at halt entry
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_once  <= 1'b0;
      step_hold  <= 1'b0;
      watch_pend <= 1'b0;
    end else begin
      // A step leaves halt for one instruction only, then halts again
      if (state == pct_pkg::PCT_ST_HALT &&
          next_state == pct_pkg::PCT_ST_FETCH) begin
        step_hold <= dbg_step_i;
      end else if (halt_now) begin
        step_hold <= 1'b0;
      end
      if (state == pct_pkg::PCT_ST_HALT &&
          next_state == pct_pkg::PCT_ST_FETCH) begin
        step_once <= 1'b1;
      end else if (issue) begin
        step_once <= 1'b0;
      end
      watch_pend <= (last && dbg_watch_en_i && cur_dec.direct &&
                     cur_op1 == dbg_watch_addr_i) ||
                    (watch_pend && !halt_now);
    end
  end

  // Retirement record, external move target and space select
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      instr_done_o <= 1'b0;
      instr_o      <= '0;
      xmove_o      <= '0;
    end else begin
      instr_done_o  <= last;
      xmove_o.valid <= last && ext_move;
      if (last) begin
        instr_o.opcode     <= cur_op;
        instr_o.op1        <= cur_op1;
        instr_o.op2        <= cur_op2;
        instr_o.nbytes     <= cur_dec.nbytes;
        instr_o.ncycles    <= cur_dec.cycles + {3'b000, taken};
        instr_o.taken      <= taken;
        instr_o.has_direct <= cur_dec.direct;
        instr_o.space      <= (cur_op1 >= pct_pkg::SPECIAL_BASE) ?
                              pct_pkg::PCT_SP_SPECIAL :
                              pct_pkg::PCT_SP_IRAM;
        xmove_o.write      <= cur_op[4];
        xmove_o.addr       <= xaddr;
        // Flash takes writes only; reads always land in data space
        if (cur_op[4] && flash_wr_en_i) begin
          xmove_o.target <= pct_pkg::PCT_XT_FLASH;
        end else if (xaddr < pct_pkg::EXT_ONCHIP_TOP) begin
          xmove_o.target <= pct_pkg::PCT_XT_ONCHIP;
        end else begin
          xmove_o.target <= pct_pkg::PCT_XT_OFFCHIP;
        end
      end
    end
  end

  // Checking helpers: clocks spent per instruction and its start address
  logic [3:0]  run_len;
  logic [15:0] start_pc;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_len  <= 4'h0;
      start_pc <= 16'h0000;
    end else begin
      run_len  <= instr_done_o ? {3'b000, exec} : run_len + {3'b000, exec};
      if (issue) begin
        start_pc <= dbg_pc_o;
      end
    end
  end

  sequence s_inc_issue;
    issue && (code_data_i == pct_pkg::OP_PTR_INC);
  endsequence

  sequence s_code_rd_step;
    (state == pct_pkg::PCT_ST_EXEC) && (cnt == 4'h1) &&
    (opcode == pct_pkg::OP_CODE_PTR_RD);
  endsequence

  reset_fetch_a: assert property (@(posedge clk_i)
    $rose(rst_b_i) |-> code_addr_o == pct_pkg::RESET_PC && !instr_done_o)
    else $error("fetch did not start at zero after reset");

  clock_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    instr_done_o |-> run_len == instr_o.ncycles)
    else $error("instruction clocks differ from its record");

  bytes_eq_clocks_a: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    instr_done_o && instr_o.opcode[3] && instr_o.opcode[7:4] != 4'hB &&
    instr_o.opcode[7:4] != 4'hD |-> instr_o.ncycles == {2'b00, instr_o.nbytes})
    else $error("register-column instruction clocks differ from bytes");

  pc_advance_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    instr_done_o && !instr_o.taken &&
    !pct_pkg::pct_decode(instr_o.opcode).jump |->
    dbg_pc_o == start_pc + {14'h0000, instr_o.nbytes})
    else $error("program counter did not advance by instruction length");

  branch_extra_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    instr_done_o |-> instr_o.ncycles ==
    pct_pkg::pct_decode(instr_o.opcode).cycles + {3'b000, instr_o.taken} &&
    (!instr_o.taken || pct_pkg::pct_decode(instr_o.opcode).cond))
    else $error("taken branch clocks wrong");

  mul_div_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    instr_done_o |-> instr_o.ncycles <= pct_pkg::MAX_CYCLES &&
    (instr_o.opcode != pct_pkg::OP_DIV || instr_o.ncycles == 4'h8) &&
    (instr_o.opcode != pct_pkg::OP_PRODUCT ||
     instr_o.ncycles == 4'h4))
    else $error("multiply, divide or longest clock count wrong");

  data_pointer_reg_inc_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_inc_issue |=> data_pointer_reg_o == $past(data_pointer_reg_o) + 16'h0001 && instr_done_o)
    else $error("data pointer increment not single clock");

  code_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_code_rd_step |=> code_addr_o == $past(data_pointer_reg_o) + {8'h00, $past(acc_i)})
    else $error("code byte read address wrong");

  flash_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    xmove_o.valid && xmove_o.target == pct_pkg::PCT_XT_FLASH |->
    xmove_o.write)
    else $error("flash chosen for an external read");

  halted_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    dbg_halted_o && $past(dbg_halted_o) |->
    $stable(code_addr_o) && !instr_done_o)
    else $error("core moved while halted");

  space_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    instr_done_o && instr_o.has_direct |->
    (instr_o.space == pct_pkg::PCT_SP_SPECIAL) == instr_o.op1[7])
    else $error("direct address space select wrong");

endmodule : pct_core

// File: verification/pct_code_mem.sv
// Program memory model with asynchronous read for the core sequencer
`timescale 1ns/1ps
module pct_code_mem (
  input  wire logic [15:0] addr_i,
  output logic      [7:0]  data_o
);
  logic [7:0] mem [0:65535];

  // Cleared image, so unused space decodes as one-clock no-ops
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end

  // Same-cycle read; the sequencer samples it at the edge after it presents the address
  assign data_o = mem[addr_i];
endmodule : pct_code_mem

// File: verification/pipelined_cpu_instr_timing_tb.sv
// Self-checking bench for the core sequencer timing and debug control
`timescale 1ns/1ps
module pipelined_cpu_instr_timing_tb;
  logic                clk_i, rst_b_i, br, fw, halt, run, step, bk_en, w_en;
  logic [15:0]         bk_addr, code_addr, data_pointer_reg, dpc;
  logic [7:0]          w_addr, code_data, op, op1, op2;
  pct_pkg::pct_instr_s instr;
  pct_pkg::pct_xmove_s xm;
  logic                done, halted, xt;
  int n_fail, samples_checked, pc, mdptr, cyc, last, gap_ok, ndone, t, nc;
  int                  a, n0, k;
  int                  starts[$];
  logic [7:0] body [20] = '{8'h28, 8'h38, 8'h98, 8'h26, 8'h36, 8'h96, 8'h56,
    8'h24, 8'h34, 8'h94, 8'h25, 8'h35, 8'h95, 8'h52, 8'h42, 8'h62, 8'h43,
    8'hA4, 8'h84, 8'h93};

  pct_core u_pct_core (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .code_data_i(code_data), .acc_i(8'h00), .ri_addr_i(8'h00),
    .branch_taken_i(br), .branch_target_i(16'h0000), .flash_wr_en_i(fw),
    .dbg_halt_i(halt), .dbg_run_i(run), .dbg_step_i(step),
    .dbg_bkpt_en_i(bk_en), .dbg_bkpt_addr_i(bk_addr), .dbg_watch_en_i(w_en),
    .dbg_watch_addr_i(w_addr), .code_addr_o(code_addr), .instr_o(instr),
    .instr_done_o(done), .data_pointer_reg_o(data_pointer_reg), .xmove_o(xm),
    .dbg_halted_o(halted), .dbg_pc_o(dpc));

  pct_code_mem u_pct_code_mem (.addr_i(code_addr), .data_o(code_data));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Bytes, clocks and direct flag per opcode, as bytes*100+clocks*10+dir
  function automatic int tim(input logic [7:0] o);
    case (o)
      8'h28, 8'h38, 8'h98, 8'hA3, 8'h00: return 110;
      8'h26, 8'h36, 8'h96, 8'h56:        return 120;
      8'h24, 8'h34, 8'h94, 8'h60:        return 220;
      8'h25, 8'h35, 8'h95, 8'h52, 8'h42, 8'h62: return 221;
      8'h53, 8'h43:                      return 331;
      8'hA4:                             return 140;
      8'h84:                             return 180;
      8'hE0, 8'hF0, 8'h93:               return 130;
      8'h90:                             return 330;
      default:                           return 0;
    endcase
  endfunction : tim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task put(input logic [7:0] b);
    u_pct_code_mem.mem[a] = b;
    a++;
  endtask : put

  // Prologue loads and bumps the pointer, then moves, random body, branch
  task build();
    logic [7:0] o;
    for (int i = 0; i < 256; i++) u_pct_code_mem.mem[i] = 8'h00;
    a = 0;
    starts = '{0, 3, 4, 5};
    put(8'h90); put(8'($urandom % 32)); put(8'hFF); put(8'hA3);
    put(8'hF0); put(8'hE0);
    o = 8'($urandom);
    w_addr <= o;
    starts.push_back(a);
    put(8'h53); put(o); put(8'($urandom));
    repeat (14) begin
      o = body[$urandom % 20];
      starts.push_back(a);
      put(o);
      for (int j = 1; j < tim(o) / 100; j++) put(8'($urandom));
    end
    put(8'h60); put(8'($urandom));
  endtask : build

  task conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Reference model walks the image and checks every retirement
  always @(negedge clk_i) begin
    cyc = cyc + 1;
    if (halted === 1'b1) gap_ok = 0;
    if (rst_b_i === 1'b1 && done === 1'b1) begin
      op  = u_pct_code_mem.mem[pc];
      op1 = u_pct_code_mem.mem[(pc + 1) % 65536];
      op2 = u_pct_code_mem.mem[(pc + 2) % 65536];
      t   = tim(op);
      nc  = t / 10 % 10 + ((op == 8'h60 && br) ? 1 : 0);
      xt  = (op == 8'hE0 || op == 8'hF0);
      chk(instr.opcode, op);
      chk(instr.nbytes, t / 100);
      chk(instr.ncycles, nc);
      if (gap_ok) chk(cyc - last, nc);
      if (t % 10) chk(instr.space, op1 >= 8'h80);
      chk(xm.valid, xt);
      if (xt) chk(xm.target, (op == 8'hF0 && fw) ? 3 :
        (mdptr < 'h1000 ? 1 : 2));
      if (xt) chk(xm.addr, mdptr);
      if (xt) chk(xm.write, op == 8'hF0);
      if (t / 100 > 1) chk(instr.op1, op1);
      if (op == 8'h90) mdptr = {op1, op2};
      if (op == 8'hA3) mdptr = (mdptr + 1) % 65536;
      pc = (op == 8'h60 && br) ? 0 : (pc + t / 100) % 65536;
      last = cyc;
      gap_ok = 1;
      ndone++;
    end
  end

  // Hang guard, well beyond three runs
  initial begin
    #400us;
    n_fail++;
    conclude();
  end

  initial begin
    {rst_b_i, br, fw, halt, run, step, bk_en, w_en} = '0;
    bk_addr = 16'h0000;
    w_addr = 8'h00;
    void'($urandom(32'h4C0C));
    for (int r = 0; r < 3; r++) begin
      rst_b_i <= 1'b0;
      build();
      repeat (8) @(posedge clk_i);
      {pc, gap_ok, mdptr} = '0;
      br <= 1'($urandom);
      fw <= 1'($urandom);
      halt <= 1'b0;
      bk_en <= (r == 1);
      bk_addr <= 16'(starts[4 + $urandom % (starts.size() - 4)]);
      w_en <= (r == 2);
      @(posedge clk_i);
      rst_b_i <= 1'b1;
      if (r == 0) begin
        for (k = 0; k < 500 && ndone < 8; k++) @(posedge clk_i);
        halt <= 1'b1;
      end
      for (k = 0; k < 4000 && halted !== 1'b1; k++) @(posedge clk_i);
      @(negedge clk_i);
      chk(halted, 1);
      chk(dpc, pc);
      chk(data_pointer_reg, mdptr);
      // One step from halt, then free running
      n0 = ndone;
      step <= 1'b1;
      @(posedge clk_i);
      step <= 1'b0;
      repeat (20) @(posedge clk_i);
      chk(ndone - n0, 1);
      chk(halted, 1);
      {halt, bk_en, w_en} <= '0;
      run <= 1'b1;
      @(posedge clk_i);
      run <= 1'b0;
      repeat (30) @(posedge clk_i);
      chk(ndone - n0 > 2, 1);
    end
    conclude();
  end
endmodule : pipelined_cpu_instr_timing_tb
